// ---- hdl/ercc_ctrl.sv ----
/*
 Third-supply configuration control: configuration lock, per-mode output
 state, voltage select, undervoltage switch-off, stop-mode power path and
 overcurrent flag.
 Assumes i_rst is the power-on reset only; soft reset arrives on
 i_soft_rst and never clears the lock. Control bits are write pulses with
 data, decoded elsewhere from the serial control registers.
*/
// Notes on behaviour
// - Stand-alone bit in normal mode selects stand-alone
// - Load-share bit selects load sharing
// - First configuration locks; later changes ignored
// - Lock survives soft reset, cleared by power
// - Stand-alone: select 0 is 5.0V, 1 is 3.3V
// - Load sharing ignores voltage select
// - Stop mode: high path follows current hysteresis
// - Normal mode uses high-power path only
// - Status reported to second supply status register
// - Input undervoltage switches off, auto re-enables
// - Keep-on bit holds supply through undervoltage
// - Share plus stop keep-on keeps supply in stop
// - Per-mode output state table
// - Load sharing follows main supply, set in normal; the write is taken in any mode
// - Change after share lock sets failure flag
// - Change after stand-alone lock sets no flag
// - Share off in stop, resumes in normal
// - Stand-alone overcurrent flag, clearable when gone
`timescale 1ns/100ps
`include "ercc_map.svh"

module ercc_ctrl #(
   parameter int SYNC_STAGES = `ERCC_SYNC_STAGES   // Synchroniser depth
) (
   input  wire logic            i_clock,           // 25 MHz clock
   input  wire logic            i_rst,             // Power-on reset, high
   input  wire logic            i_ce,              // Clock enable
   input  wire logic            i_soft_rst,        // Soft reset pulse
   input  wire ercc_pkg::ercc_mode_t i_mode,       // System operating mode
   input  wire logic            i_standalone_wr,   // Write of stand-alone bit
   input  wire logic            i_standalone_enable_bit, // Stand-alone bit data
   input  wire logic            i_load_share_wr,   // Write of hardware control reg
   input  wire logic            i_load_share_enable_bit, // Load-share bit data
   input  wire logic            i_third_supply_voltage_select, // 0 5.0V, 1 3.3V
   input  wire logic            i_undervoltage_keep_on_bit,    // Keep on in UV
   input  wire logic            i_stop_mode_share_keep_on,     // Share kept in stop
   input  wire logic            i_uv_comp_async,   // Input below UV threshold
   input  wire logic            i_base_above_rise, // Base current over rising thr
   input  wire logic            i_base_below_fall, // Base current under falling thr
   input  wire logic            i_shunt_limit,     // Shunt threshold reached
   input  wire logic            i_oc_clear,        // Overcurrent flag clear pulse
   input  wire logic            i_main_supply_on,  // Main regulator state
   output ercc_pkg::ercc_cfg_t  o_cfg,             // Locked configuration
   output logic                 o_locked,          // Configuration locked
   output logic                 o_third_supply_en, // Drive enable of regulator
   output logic                 o_vsel_3v3,        // High selects 3.3 V
   output logic                 o_high_path_en,    // High-power path on
   output logic                 o_spi_fail_set,    // Failure flag set pulse
   output logic                 o_third_supply_overcurrent_flag,  // Sticky OC
   output logic                 o_third_supply_undervoltage_flag  // UV status
);
   import ercc_pkg::*;

   ercc_cfg_t cfg_r, cfg_nxt;               // Locked configuration
   logic      soft_alone_r, soft_alone_nxt; // Stand-alone on/off setting
   logic      vsel_r, vsel_nxt;             // Latched voltage select
   logic      hp_r, hp_nxt;                 // Stop-mode high path state
   logic      oc_r, oc_nxt;                 // Overcurrent sticky flag
   logic      fail_r, fail_nxt;             // Failure set pulse
   logic      en_r, en_nxt;                 // Supply enable
   logic      uv_flag_r, uv_flag_nxt;       // Undervoltage status
   logic      uv_sync;                      // Synchronised comparator
   logic      uv_cut;                       // Undervoltage switch-off

   ercc_sync #(
      .STAGES  (SYNC_STAGES)
   ) u_uv_sync (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .i_ce    (i_ce),
      .i_async (i_uv_comp_async),
      .o_sync  (uv_sync)
   );

   // Mode table decision for a given configuration
   // Stand-alone holds its on/off setting outside init and fail-safe;
   // load sharing mirrors the main regulator wherever it may run at all.
   function automatic logic mode_on(input ercc_mode_t m, input ercc_cfg_t c,
                                    input logic held, input logic keep,
                                    input logic main_on);
      logic r;
      r = 1'b0;
      if (c == ERCC_CFG_ALONE) begin
         case (m)
            ERCC_NORMAL, ERCC_STOP, ERCC_SLEEP, ERCC_RESTRT: r = held;
            default:                                          r = 1'b0;
         endcase
      end else if (c == ERCC_CFG_SHARE) begin
         case (m)
            ERCC_NORMAL, ERCC_RESTRT: r = main_on;
            // kept on in stop; else off, bit stays
            ERCC_STOP:                r = keep & main_on;
            default:                  r = 1'b0;
         endcase
      end
      return r;
   endfunction

   // Keep-on masks only the switch-off; the status flag still reports
   // the undervoltage so software can see why the input sagged.
   // switch off below threshold; keep-on overrides
   assign uv_cut = uv_sync & ~i_undervoltage_keep_on_bit;

   // Next-state logic for configuration and status
   always_comb begin
      cfg_nxt        = cfg_r;
      soft_alone_nxt = soft_alone_r;
      vsel_nxt       = vsel_r;
      hp_nxt         = hp_r;
      oc_nxt         = oc_r;
      fail_nxt       = 1'b0;
      // lock only ever set; soft reset and modes leave it
      if (cfg_r == ERCC_CFG_NONE) begin
         // load share wins if both written together
         if (i_load_share_wr && i_load_share_enable_bit) begin
            cfg_nxt = ERCC_CFG_SHARE;
         // stand-alone taken in normal mode only
         end else if (i_standalone_wr && i_standalone_enable_bit &&
                      i_mode == ERCC_NORMAL) begin
            cfg_nxt        = ERCC_CFG_ALONE;
            soft_alone_nxt = 1'b1;
         end
      end else if (cfg_r == ERCC_CFG_SHARE) begin
         // change attempt flags failure, config kept
         if ((i_standalone_wr && i_standalone_enable_bit) ||
             (i_load_share_wr && !i_load_share_enable_bit)) begin
            fail_nxt = 1'b1;
         end
      end else begin
         // switch on/off allowed, no failure flag
         if (i_standalone_wr && i_mode == ERCC_NORMAL) begin
            soft_alone_nxt = i_standalone_enable_bit;
         end
      end
      if (cfg_nxt == ERCC_CFG_ALONE) begin
         // 0 gives 5.0 V, 1 gives 3.3 V
         vsel_nxt = i_third_supply_voltage_select;
      end else begin
         vsel_nxt = `ERCC_VSEL_5V0;
      end
      // normal uses high path; stop uses hysteresis
      if (i_mode == ERCC_STOP) begin
         if (i_base_above_rise) begin
            hp_nxt = 1'b1;
         end else if (i_base_below_fall) begin
            hp_nxt = 1'b0;
         end
      end else begin
         hp_nxt = (i_mode == ERCC_NORMAL) || (i_mode == ERCC_RESTRT);
      end
      // set wins over clear; clear only once gone
      if (cfg_r == ERCC_CFG_ALONE && i_shunt_limit) begin
         oc_nxt = 1'b1;
      end else if (i_oc_clear) begin
         oc_nxt = 1'b0;
      end
      // Soft reset turns the stand-alone output off, lock stays
      if (i_soft_rst) begin
         soft_alone_nxt = 1'b0;
         oc_nxt         = 1'b0;
      end
      // Enable lags a mode change by one cycle, undervoltage by three
      en_nxt = mode_on(i_mode, cfg_r, soft_alone_r, i_stop_mode_share_keep_on,
                       i_main_supply_on) & ~uv_cut;
      uv_flag_nxt = (cfg_r == ERCC_CFG_ALONE) & uv_sync;
   end

   // Registers; lock cleared only by power-on reset
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         cfg_r        <= ERCC_CFG_NONE;
         soft_alone_r <= 1'b0;
         vsel_r       <= `ERCC_VSEL_5V0;
         hp_r         <= 1'b0;
         oc_r         <= 1'b0;
         fail_r       <= 1'b0;
         en_r         <= 1'b0;
         uv_flag_r    <= 1'b0;
      end else if (i_ce) begin
         cfg_r        <= cfg_nxt;
         soft_alone_r <= soft_alone_nxt;
         vsel_r       <= vsel_nxt;
         hp_r         <= hp_nxt;
         oc_r         <= oc_nxt;
         fail_r       <= fail_nxt;
         en_r         <= en_nxt;
         uv_flag_r    <= uv_flag_nxt;
      end
   end

   // Outputs from flip-flops; lock is decoded from the configuration
   // High path is gated by the enable so a parked hysteresis state
   // never shows while the supply itself is off.
   assign o_cfg                            = cfg_r;
   assign o_locked                         = (cfg_r != ERCC_CFG_NONE);
   assign o_third_supply_en                = en_r;
   assign o_vsel_3v3                       = vsel_r;
   assign o_high_path_en                   = hp_r & en_r;
   assign o_spi_fail_set                   = fail_r;
   assign o_third_supply_overcurrent_flag  = oc_r;
   assign o_third_supply_undervoltage_flag = uv_flag_r;
endmodule

// ---- hdl/ercc_map.svh ----
/*
 Constants for the third-supply configuration control block.
 Assumes inclusion by bare name from the block package and modules.
*/
`ifndef ERCC_MAP_SVH
`define ERCC_MAP_SVH

// Mode code width and values
`define ERCC_MODE_W      3
`define ERCC_MODE_INIT   3'h0
`define ERCC_MODE_NORMAL 3'h1
`define ERCC_MODE_STOP   3'h2
`define ERCC_MODE_SLEEP  3'h3
`define ERCC_MODE_RESTRT 3'h4
`define ERCC_MODE_FSAFE  3'h5

// Configuration codes
`define ERCC_CFG_NONE    2'h0
`define ERCC_CFG_ALONE   2'h1
`define ERCC_CFG_SHARE   2'h2

// Voltage select codes: 0 gives 5.0 V, 1 gives 3.3 V
`define ERCC_VSEL_5V0    1'h0
`define ERCC_VSEL_3V3    1'h1

// Synchroniser depth
`define ERCC_SYNC_STAGES 2

`endif

// ---- hdl/ercc_pkg.sv ----
/*
 Types for the third-supply configuration control block.
 Assumes ercc_map.svh is on the include path.
*/
`include "ercc_map.svh"

package ercc_pkg;
   // System operating mode
   typedef enum logic [2:0] {
      ERCC_INIT   = 3'b000,
      ERCC_NORMAL = 3'b001,
      ERCC_STOP   = 3'b010,
      ERCC_SLEEP  = 3'b011,
      ERCC_RESTRT = 3'b100,
      ERCC_FSAFE  = 3'b101
   } ercc_mode_t;

   // Locked configuration state
   typedef enum logic [1:0] {
      ERCC_CFG_NONE  = 2'b00,
      ERCC_CFG_ALONE = 2'b01,
      ERCC_CFG_SHARE = 2'b10
   } ercc_cfg_t;
endpackage

// ---- hdl/ercc_sync.sv ----
/*
 Multi-stage level synchroniser with clock enable.
 Assumes a level input from a foreign timing source.
*/
`timescale 1ns/100ps

module ercc_sync #(
   parameter int STAGES = 2                   // Flip-flops in chain
) (
   input  wire logic i_clock,                 // System clock
   input  wire logic i_rst,                   // Async reset, high
   input  wire logic i_ce,                    // Clock enable
   input  wire logic i_async,                 // Unsynchronised level
   output logic      o_sync                   // Synchronised level
);
   logic [STAGES-1:0] chain_r;                // Shift chain
   logic [STAGES-1:0] chain_nxt;              // Next chain value

   // Shift in; only the last stage is read outside
   always_comb begin
      chain_nxt = {chain_r[STAGES-2:0], i_async};
   end

   // Register the chain
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         chain_r <= '0;
      end else if (i_ce) begin
         chain_r <= chain_nxt;
      end
   end

   assign o_sync = chain_r[STAGES-1];
endmodule

// ---- verif/ercc_ctrl_props.sv ----
/*
 Port-level assertions for the third-supply configuration control.
 Assumes a single clock domain and i_rst as the power-on reset.
*/
`timescale 1ns/100ps

module ercc_ctrl_props
   import ercc_pkg::*;
#(
   parameter int SYNC_STAGES = 2                  // Synchroniser depth
) (
   input wire logic       i_clock,
   input wire logic       i_rst,
   input wire logic       i_ce,
   input wire logic       i_soft_rst,
   input wire ercc_mode_t i_mode,
   input wire logic       i_standalone_wr,
   input wire logic       i_standalone_enable_bit,
   input wire logic       i_load_share_wr,
   input wire logic       i_load_share_enable_bit,
   input wire logic       i_third_supply_voltage_select,
   input wire logic       i_undervoltage_keep_on_bit,
   input wire logic       i_stop_mode_share_keep_on,
   input wire logic       i_uv_comp_async,
   input wire logic       i_base_above_rise,
   input wire logic       i_base_below_fall,
   input wire logic       i_shunt_limit,
   input wire logic       i_oc_clear,
   input wire logic       i_main_supply_on,
   input wire ercc_cfg_t  o_cfg,
   input wire logic       o_locked,
   input wire logic       o_third_supply_en,
   input wire logic       o_vsel_3v3,
   input wire logic       o_high_path_en,
   input wire logic       o_spi_fail_set,
   input wire logic       o_third_supply_overcurrent_flag,
   input wire logic       o_third_supply_undervoltage_flag
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   // Undervoltage held long enough to cross the synchroniser
   sequence s_uv_held;
      (i_uv_comp_async && !i_undervoltage_keep_on_bit && i_ce) [*3];
   endsequence
   // Share write while unlocked
   sequence s_share_wr;
      !o_locked && i_ce && i_load_share_wr && i_load_share_enable_bit;
   endsequence

   property p_lock_hold;
      o_locked |=> o_locked && $stable(o_cfg);
   endproperty
   property p_share_sel;
      s_share_wr |=> o_cfg == ERCC_CFG_SHARE;
   endproperty
   property p_alone_sel;
      !o_locked && i_ce && i_standalone_wr && i_standalone_enable_bit
      && i_mode == ERCC_NORMAL && !i_load_share_wr |=> o_cfg == ERCC_CFG_ALONE;
   endproperty
   property p_share_fail;
      o_cfg == ERCC_CFG_SHARE && i_ce && i_mode == ERCC_NORMAL
      && (i_standalone_wr && i_standalone_enable_bit
      || i_load_share_wr && !i_load_share_enable_bit) |=> o_spi_fail_set;
   endproperty
   property p_alone_quiet;
      o_cfg == ERCC_CFG_ALONE |=> !o_spi_fail_set;
   endproperty
   property p_vsel;
      i_ce && o_locked |=> o_vsel_3v3
         == (o_cfg == ERCC_CFG_ALONE && $past(i_third_supply_voltage_select));
   endproperty
   property p_off_modes;
      i_ce && (i_mode == ERCC_INIT || i_mode == ERCC_FSAFE) |=> !o_third_supply_en;
   endproperty
   property p_uv_off;
      s_uv_held |=> !o_third_supply_en;
   endproperty
   property p_stop_off;
      o_cfg == ERCC_CFG_SHARE && i_mode == ERCC_STOP && i_ce
      && !i_stop_mode_share_keep_on |=> !o_third_supply_en;
   endproperty
   property p_hp_normal;
      i_ce && i_mode == ERCC_NORMAL |=> o_high_path_en == o_third_supply_en;
   endproperty
   property p_uv_flag;
      i_ce && o_cfg != ERCC_CFG_ALONE |=> !o_third_supply_undervoltage_flag;
   endproperty
   property p_oc_set;
      o_cfg == ERCC_CFG_ALONE && i_ce && i_shunt_limit && !i_soft_rst
      |=> o_third_supply_overcurrent_flag;
   endproperty

   a_lock_hold: assert property (p_lock_hold) else $error("lock changed");
   a_share_sel: assert property (p_share_sel) else $error("share not set");
   a_alone_sel: assert property (p_alone_sel) else $error("alone not set");
   a_share_fail: assert property (p_share_fail) else $error("no fail pulse");
   a_alone_quiet: assert property (p_alone_quiet) else $error("fail pulse");
   a_vsel: assert property (p_vsel) else $error("vsel wrong");
   a_off_modes: assert property (p_off_modes) else $error("on in off mode");
   a_uv_off: assert property (p_uv_off) else $error("on in undervoltage");
   a_stop_off: assert property (p_stop_off) else $error("share on in stop");
   a_oc_set: assert property (p_oc_set) else $error("overcurrent missed");
   a_hp_normal: assert property (p_hp_normal) else $error("high path off in normal");
   a_uv_flag: assert property (p_uv_flag) else $error("uv flag outside stand-alone");
endmodule

bind ercc_ctrl ercc_ctrl_props #(.SYNC_STAGES(SYNC_STAGES)) u_props (.*);

// ---- verif/tb_ercc_ctrl.sv ----
/*
 Self-checking bench for the third-supply configuration control.
 Assumes i_rst is power-on reset; inputs driven on falling edges.
*/
`timescale 1ns/100ps

module tb_ercc_ctrl;
   import ercc_pkg::*;
   logic       i_clock, i_rst, i_ce, i_soft_rst, i_standalone_wr, i_standalone_enable_bit;
   logic       i_load_share_wr, i_load_share_enable_bit, i_third_supply_voltage_select;
   logic       i_undervoltage_keep_on_bit, i_stop_mode_share_keep_on, i_uv_comp_async;
   logic       i_base_above_rise, i_base_below_fall, i_shunt_limit, i_oc_clear;
   logic       i_main_supply_on, o_locked, o_third_supply_en, o_vsel_3v3, o_high_path_en;
   logic       o_spi_fail_set, o_third_supply_overcurrent_flag, o_third_supply_undervoltage_flag;
   ercc_mode_t i_mode;
   ercc_cfg_t  o_cfg;
   logic [17:0] exp_q[$];                          // Mask and value notes
   logic [17:0] q;
   int         bad_count, compares;
   // Masks: high path, UV flag, config and lock, enable, voltage, fail, overcurrent
   localparam logic [8:0] MH = 9'h100, MU = 9'h080, MC = 9'h070, ME = 9'h008;
   localparam logic [8:0] MV = 9'h004, MF = 9'h002, MO = 9'h001;
   ercc_mode_t mt[7] = '{ERCC_STOP, ERCC_STOP, ERCC_SLEEP, ERCC_RESTRT, ERCC_INIT,
                         ERCC_FSAFE, ERCC_NORMAL};
   wire [8:0]  obs = {o_high_path_en, o_third_supply_undervoltage_flag, o_cfg, o_locked,
                      o_third_supply_en, o_vsel_3v3, o_spi_fail_set,
                      o_third_supply_overcurrent_flag};

   ercc_ctrl u_dut (.*);

   initial begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end

   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED outputs expected %h seen %h", exp, seen);
      end
   endtask

   // Notes what the next rising edge must produce, then moves on
   task automatic step(input logic [8:0] m, input logic [8:0] e);
      exp_q.push_back({m, e & m});
      @(negedge i_clock);
   endtask

   task automatic nx(input int n);
      repeat (n) @(negedge i_clock);
   endtask

   task automatic por;
      i_rst = 1'b1;
      nx(6);
      i_rst = 1'b0;
   endtask

   // Walks the mode table; share enable also needs the main supply
   task automatic modes(input logic [6:0] se, input logic sh);
      foreach (mt[k]) begin
         i_mode = mt[k];
         i_stop_mode_share_keep_on = (k == 1);
         i_main_supply_on = 1'($urandom);
         {i_base_above_rise, i_base_below_fall} = 2'($urandom);
         step(ME, {5'b0, se[k] & (i_main_supply_on | ~sh), 3'b0});
      end
      i_main_supply_on = 1'b1;
   endtask

   task automatic wrap_up;
      $display("Mismatches %0d of %0d compares", bad_count, compares);
      if (bad_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Result watcher: compares after each rising edge has settled
   always @(posedge i_clock) begin
      #10;
      if (exp_q.size() > 0) begin
         q = exp_q.pop_front();
         check(obs & q[17:9], q[8:0]);
      end
   end

   initial begin
      i_rst = 1'b1;
      i_ce = 1'b1;
      i_main_supply_on = 1'b1;
      i_mode = ERCC_INIT;
      {i_soft_rst, i_standalone_wr, i_standalone_enable_bit, i_load_share_wr} = '0;
      {i_load_share_enable_bit, i_third_supply_voltage_select, i_oc_clear} = '0;
      {i_undervoltage_keep_on_bit, i_stop_mode_share_keep_on, i_uv_comp_async} = '0;
      {i_base_above_rise, i_base_below_fall, i_shunt_limit} = '0;
      void'($urandom(79));
      por();
      step(9'h1FF, 9'h000);
      i_mode = ERCC_NORMAL;
      {i_load_share_wr, i_load_share_enable_bit, i_standalone_wr, i_standalone_enable_bit} = 4'hF;
      step(MC, 9'h050);
      {i_load_share_wr, i_load_share_enable_bit, i_standalone_wr} = 3'b010;
      i_third_supply_voltage_select = 1'b1;
      step(ME | MV | MH, 9'h108);
      i_standalone_wr = 1'b1;
      step(MC | MF, 9'h052);
      {i_standalone_wr, i_load_share_wr, i_load_share_enable_bit} = 3'b010;
      step(MC | MF, 9'h052);
      i_load_share_wr = 1'b0;
      i_soft_rst = 1'b1;
      step(MC | MF, 9'h050);
      i_soft_rst = 1'b0;
      modes(7'b1001010, 1'b1);
      i_uv_comp_async = 1'b1;
      i_shunt_limit = 1'b1;
      nx(2);
      step(ME | MO | MU, 9'h000);
      {i_uv_comp_async, i_shunt_limit} = 2'b00;
      nx(2);
      step(ME, 9'h008);
      // Power loss: the only way back to an open configuration
      por();
      step(MC, 9'h000);
      i_mode = ERCC_STOP;
      {i_standalone_wr, i_standalone_enable_bit} = 2'b11;
      step(MC, 9'h000);
      i_mode = ERCC_NORMAL;
      step(MC, 9'h030);
      {i_standalone_wr, i_load_share_wr, i_load_share_enable_bit} = 3'b011;
      step(MC | MF | ME, 9'h038);
      i_load_share_wr = 1'b0;
      repeat (4) begin
         i_third_supply_voltage_select = 1'($urandom);
         step(MV, {6'b0, i_third_supply_voltage_select, 2'b0});
      end
      // Stop-mode hysteresis: fall clears, idle holds, rise sets, idle holds
      i_mode = ERCC_STOP;
      {i_base_above_rise, i_base_below_fall} = 2'b01;
      step(MH | ME, 9'h008);
      {i_base_above_rise, i_base_below_fall} = 2'b00;
      step(MH, 9'h000);
      {i_base_above_rise, i_base_below_fall} = 2'b10;
      step(MH, 9'h100);
      {i_base_above_rise, i_base_below_fall} = 2'b00;
      step(MH, 9'h100);
      i_mode = ERCC_NORMAL;
      {i_base_above_rise, i_base_below_fall} = 2'b01;
      step(MH, 9'h100);
      modes(7'b1001111, 1'b0);
      {i_undervoltage_keep_on_bit, i_uv_comp_async} = 2'b11;
      nx(2);
      step(ME | MU, 9'h088);
      i_undervoltage_keep_on_bit = 1'b0;
      step(ME, 9'h000);
      i_uv_comp_async = 1'b0;
      nx(2);
      step(ME | MU, 9'h008);
      {i_shunt_limit, i_oc_clear} = 2'b11;
      step(MO, 9'h001);
      i_shunt_limit = 1'b0;
      step(MO, 9'h000);
      i_oc_clear = 1'b0;
      // Clock enable low: the write must wait and nothing may move
      {i_standalone_wr, i_standalone_enable_bit} = 2'b10;
      i_ce = 1'b0;
      step(MC | ME | MO, 9'h038);
      i_ce = 1'b1;
      step(MC, 9'h030);
      i_standalone_wr = 1'b0;
      step(ME, 9'h000);
      for (int k = 0; k < 4 && exp_q.size() > 0; k++) @(negedge i_clock);
      if (exp_q.size() > 0) bad_count++;
      wrap_up();
   end
endmodule
